// ---- rtl/two_wire_slave_pkg.sv ----
/*
 Package for the two-wire slave receiver: register offsets, control and status layouts,
 status codes and the packed carriers shared by the design.
 Assumes a 32-bit APB register bus and a 100 MHz pclk.
*/
package two_wire_slave_pkg;

   // ------------------------------------------------------------------
   // Register map
   // ------------------------------------------------------------------
   localparam logic [7:0] OFS_OWN_SLAVE_ADDRESS = 8'h00;
   localparam logic [7:0] OFS_BUS_CONTROL_REG = 8'h04;
   localparam logic [7:0] OFS_BUS_STATUS_REG = 8'h08;
   localparam logic [7:0] OFS_BUS_DATA_REG = 8'h0C;
   localparam logic [7:0] OFS_SLEEP_CTRL = 8'h10;

   localparam logic [7:0] RST_OWN_SLAVE_ADDRESS = 8'h00;
   localparam logic [7:0] RST_BUS_CONTROL_REG = 8'h00;

   // Control register bit positions.
   localparam int CTL_EVENT_FLAG = 7;
   localparam int CTL_ACK_ENABLE = 6;
   localparam int CTL_START_REQUEST = 5;
   localparam int CTL_STOP_REQUEST = 4;
   localparam int CTL_IFACE_ENABLE = 2;
   // Address register: general call enable in the least significant bit.
   localparam int ADR_GENERAL_CALL_ENABLE = 0;

   // ------------------------------------------------------------------
   // Status codes (low three bits read as zero)
   // ------------------------------------------------------------------
   localparam logic [7:0] ST_OWN_WRITE = 8'h60;
   localparam logic [7:0] ST_ARB_OWN_WRITE = 8'h68;
   localparam logic [7:0] ST_GENERAL_CALL = 8'h70;
   localparam logic [7:0] ST_ARB_GENERAL_CALL = 8'h78;
   localparam logic [7:0] ST_OWN_DATA_ACK = 8'h80;
   localparam logic [7:0] ST_OWN_DATA_NACK = 8'h88;
   localparam logic [7:0] ST_GC_DATA_ACK = 8'h90;
   localparam logic [7:0] ST_GC_DATA_NACK = 8'h98;
   localparam logic [7:0] ST_OWN_READ = 8'hA8;
   localparam logic [7:0] ST_LAST_BYTE_ACKED = 8'hC8;
   localparam logic [7:0] ST_IDLE = 8'hF8;

   localparam logic [6:0] GENERAL_CALL_ADDRESS = 7'h00;
   localparam logic [3:0] BITS_PER_BYTE = 4'h8;

   typedef enum logic [2:0] {
      S_IDLE = 3'b000,
      S_ADDR = 3'b001,
      S_ADDR_ACK = 3'b011,
      S_DATA = 3'b010,
      S_DATA_ACK = 3'b110,
      S_TX = 3'b111,
      S_TX_ACK = 3'b101,
      S_IGNORE = 3'b100
   } link_state_t;

   typedef struct packed {
      logic [7:0] own_slave_address;
      logic ack_enable;
      logic iface_enable;
      logic start_request;
      logic stop_request;
      logic event_flag;
      logic [7:0] status;
      logic [7:0] bus_data_reg;
      logic [7:0] tx_byte;
      logic deep_sleep;
      logic wake_req;
      logic wake_hold;
      logic arb_lost;
      logic start_pending;
      logic bus_busy;
      logic last_tx;
   } regs_t;

   typedef struct packed {
      link_state_t st;
      logic [7:0] shift;
      logic [3:0] bit_cnt;
      logic gc;
      logic sda_low;
      logic scl_low;
      logic [1:0] scl_sync;
      logic [1:0] sda_sync;
      logic scl_q;
      logic sda_q;
   } link_t;

   typedef struct packed {
      logic [31:0] prdata;
      logic pready;
      logic pslverr;
   } apb_resp_t;

   typedef struct packed {
      regs_t r;
      link_t l;
      apb_resp_t b;
   } state_t;

endpackage : two_wire_slave_pkg

// ---- rtl/two_wire_slave_receiver.sv ----
/*
 Two-wire slave receiver with APB register access, clock stretching and wake on address.
 Assumes SCL and SDA arrive asynchronously as open-drain levels, sampled by pclk which
 must run well above the bus clock; the master side is an ordinary bus master.
*/
// The placing of the registers and the APB slave port were chosen for this implementation.
`timescale 1ns/1ns
module two_wire_slave_receiver #(
   parameter int ADDR_BITS = 7
) (
   // APB clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // APB slave
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // Two-wire bus pins, open drain
   input wire logic scl_in,
   output logic scl_out,
   output logic scl_oe,
   input wire logic sda_in,
   output logic sda_out,
   output logic sda_oe,
   // System side
   input wire logic arb_lost_in,
   output logic wake_req,
   output logic start_issue
);
   import two_wire_slave_pkg::*;

   state_t q;
   state_t next_q;
   logic start_q;
   logic next_start;

   // ------------------------------------------------------------------
   // Elaboration checks
   // ------------------------------------------------------------------
   // The address compare and the shift register serve seven-bit addresses only.
   if (ADDR_BITS != $bits(GENERAL_CALL_ADDRESS)) begin : g_addr_bits_check
      $error("two_wire_slave_receiver serves seven-bit bus addresses only");
   end

   // ------------------------------------------------------------------
   // Helpers
   // ------------------------------------------------------------------
   // Address match: own address always, general call only when enabled.
   function automatic logic [1:0] addr_match(input logic [6:0] a, input logic [7:0] own);
      logic [1:0] m;
      m = 2'b00;
      if (a == own[7:1]) begin
         m[0] = 1'b1;
      end
      if (a == GENERAL_CALL_ADDRESS && own[ADR_GENERAL_CALL_ENABLE]) begin
         m[1] = 1'b1;
      end
      return m;
   endfunction : addr_match

   function automatic logic is_write(input logic [7:0] ofs, input logic [7:0] pa,
                                     input logic acc);
      return acc && (pa == ofs);
   endfunction : is_write

   // ------------------------------------------------------------------
   // Next state
   // ------------------------------------------------------------------
   always_comb begin
      logic scl, sda, scl_rise, scl_fall, start_c, stop_c, acc, wr;
      logic [1:0] m;
      logic [7:0] shifted;
      next_q = q;
      next_start = 1'b0;
      scl = q.l.scl_sync[1];
      sda = q.l.sda_sync[1];
      next_q.l.scl_sync = {q.l.scl_sync[0], scl_in};
      next_q.l.sda_sync = {q.l.sda_sync[0], sda_in};
      next_q.l.scl_q = scl;
      next_q.l.sda_q = sda;
      scl_rise = scl && !q.l.scl_q;
      scl_fall = !scl && q.l.scl_q;
      start_c = scl && q.l.scl_q && q.l.sda_q && !sda;
      stop_c = scl && q.l.scl_q && !q.l.sda_q && sda;
      shifted = {q.l.shift[6:0], sda};
      m = addr_match(q.l.shift[7:1], q.r.own_slave_address);
      acc = psel && penable;
      wr = acc && pwrite;

      // APB: one wait state, unmapped reads give zero and an error.
      next_q.b.pready = acc && !q.b.pready;
      next_q.b.pslverr = 1'b0;
      next_q.b.prdata = '0;
      if (acc && !q.b.pready) begin
         unique case (paddr)
            OFS_OWN_SLAVE_ADDRESS: next_q.b.prdata[7:0] = q.r.own_slave_address;
            OFS_BUS_CONTROL_REG: next_q.b.prdata[7:0] = {q.r.event_flag, q.r.ack_enable,
               q.r.start_request, q.r.stop_request, 1'b0, q.r.iface_enable, 2'b00};
            OFS_BUS_STATUS_REG: next_q.b.prdata[7:0] = q.r.status;
            OFS_BUS_DATA_REG: next_q.b.prdata[7:0] = q.r.bus_data_reg;
            OFS_SLEEP_CTRL: next_q.b.prdata[1:0] = {q.r.wake_req, q.r.deep_sleep};
            default: next_q.b.pslverr = 1'b1;
         endcase
      end

      if (is_write(OFS_OWN_SLAVE_ADDRESS, paddr, wr && !q.b.pready)) begin
         next_q.r.own_slave_address = pwdata[7:0];
      end
      if (is_write(OFS_BUS_DATA_REG, paddr, wr && !q.b.pready)) begin
         next_q.r.tx_byte = pwdata[7:0];
      end
      if (is_write(OFS_SLEEP_CTRL, paddr, wr && !q.b.pready)) begin
         next_q.r.deep_sleep = pwdata[0];
         next_q.r.wake_req = q.r.wake_req && !pwdata[1];
      end
      if (is_write(OFS_BUS_CONTROL_REG, paddr, wr && !q.b.pready)) begin
         next_q.r.ack_enable = pwdata[CTL_ACK_ENABLE];
         next_q.r.iface_enable = pwdata[CTL_IFACE_ENABLE];
         next_q.r.start_request = pwdata[CTL_START_REQUEST];
         next_q.r.stop_request = pwdata[CTL_STOP_REQUEST];
         if (pwdata[CTL_EVENT_FLAG] && q.r.event_flag) begin
            next_q.r.event_flag = 1'b0;
            next_q.r.wake_hold = 1'b0;
            next_q.r.status = ST_IDLE;
            next_q.l.scl_low = 1'b0;
            // Leaving a terminal state arms the START request.
            if (q.l.st == S_IDLE && pwdata[CTL_START_REQUEST]) begin
               next_q.r.start_pending = 1'b1;
            end
            // The outgoing byte and the last-byte choice are taken again at this
            // release, so software may load the data register after the status.
            if (q.l.st == S_TX) begin
               next_q.l.shift = q.r.tx_byte;
               next_q.r.last_tx = !pwdata[CTL_ACK_ENABLE];
            end
         end
      end

      // Arbitration loss is remembered until the next addressed write reports it.
      if (arb_lost_in) begin
         next_q.r.arb_lost = 1'b1;
      end
      if (start_c) begin
         next_q.r.bus_busy = 1'b1;
      end
      if (stop_c) begin
         next_q.r.bus_busy = 1'b0;
      end
      if (q.r.start_pending && !q.r.bus_busy && !start_c) begin
         next_start = 1'b1;
         next_q.r.start_pending = 1'b0;
      end

      // Bus engine; it only runs with the interface enabled.
      if (!q.r.iface_enable) begin
         next_q.l.st = S_IDLE;
         next_q.l.sda_low = 1'b0;
         next_q.l.scl_low = 1'b0;
      end else if (stop_c) begin
         next_q.l.st = S_IDLE;
         next_q.l.sda_low = 1'b0;
      end else if (start_c) begin
         next_q.l.st = S_ADDR;
         next_q.l.bit_cnt = '0;
         next_q.l.sda_low = 1'b0;
      end else begin
         case (q.l.st)
            S_ADDR, S_DATA: begin
               if (scl_rise) begin
                  next_q.l.shift = shifted;
                  next_q.l.bit_cnt = q.l.bit_cnt + 4'h1;
               end
               if (scl_fall && q.l.bit_cnt == BITS_PER_BYTE) begin
                  next_q.l.bit_cnt = '0;
                  if (q.l.st == S_ADDR) begin
                     if ((m != 2'b00) && q.r.ack_enable) begin
                        next_q.l.st = S_ADDR_ACK;
                        next_q.l.sda_low = 1'b1;
                        next_q.l.gc = !m[0];
                        if (q.r.deep_sleep) begin
                           next_q.r.wake_req = 1'b1;
                           next_q.r.wake_hold = 1'b1;
                        end
                     end else begin
                        next_q.l.st = S_IGNORE;
                     end
                  end else begin
                     next_q.l.st = S_DATA_ACK;
                     next_q.l.sda_low = q.r.ack_enable;
                     // The data register is not refreshed while waking up.
                     if (!q.r.wake_hold) begin
                        next_q.r.bus_data_reg = q.l.shift;
                     end
                  end
               end
            end
            S_ADDR_ACK: begin
               if (scl_fall) begin
                  next_q.l.sda_low = 1'b0;
                  next_q.r.event_flag = 1'b1;
                  next_q.l.scl_low = 1'b1;
                  if (q.l.shift[0]) begin
                     next_q.l.st = S_TX;
                     next_q.r.status = ST_OWN_READ;
                     next_q.r.last_tx = !q.r.ack_enable;
                     next_q.l.shift = q.r.tx_byte;
                  end else begin
                     next_q.l.st = S_DATA;
                     if (q.l.gc) begin
                        next_q.r.status = q.r.arb_lost ? ST_ARB_GENERAL_CALL : ST_GENERAL_CALL;
                     end else begin
                        next_q.r.status = q.r.arb_lost ? ST_ARB_OWN_WRITE : ST_OWN_WRITE;
                     end
                     next_q.r.arb_lost = 1'b0;
                  end
               end
            end
            S_DATA_ACK: begin
               if (scl_fall) begin
                  next_q.l.sda_low = 1'b0;
                  next_q.r.event_flag = 1'b1;
                  next_q.l.scl_low = 1'b1;
                  if (q.r.ack_enable) begin
                     next_q.l.st = S_DATA;
                     next_q.r.status = q.l.gc ? ST_GC_DATA_ACK : ST_OWN_DATA_ACK;
                  end else begin
                     next_q.l.st = S_IDLE;
                     next_q.r.status = q.l.gc ? ST_GC_DATA_NACK : ST_OWN_DATA_NACK;
                  end
               end
            end
            S_TX: begin
               // Shift out MSB first while the flag is clear.
               if (!q.l.scl_low) begin
                  next_q.l.sda_low = !q.l.shift[7];
                  if (scl_fall) begin
                     next_q.l.shift = {q.l.shift[6:0], 1'b1};
                     next_q.l.bit_cnt = q.l.bit_cnt + 4'h1;
                     if (q.l.bit_cnt == BITS_PER_BYTE - 4'h1) begin
                        next_q.l.st = S_TX_ACK;
                        next_q.l.sda_low = 1'b0;
                     end
                  end
               end
            end
            S_TX_ACK: begin
               if (scl_rise) begin
                  next_q.l.bit_cnt = '0;
                  if (q.r.last_tx && !sda) begin
                     next_q.l.st = S_IDLE;
                     next_q.r.status = ST_LAST_BYTE_ACKED;
                     next_q.r.event_flag = 1'b1;
                  end else begin
                     // Only one byte per read is served; the rest waits for a new START.
                     next_q.l.st = S_IGNORE;
                  end
               end
            end
            S_IGNORE, S_IDLE: begin
               next_q.l.sda_low = 1'b0;
            end
            default: next_q.l.st = S_IDLE;
         endcase
      end
   end

   // ------------------------------------------------------------------
   // State register
   // ------------------------------------------------------------------
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         q <= '0;
         q.r.own_slave_address <= RST_OWN_SLAVE_ADDRESS;
         q.r.status <= ST_IDLE;
         q.l.scl_sync <= 2'b11;
         q.l.sda_sync <= 2'b11;
         q.l.scl_q <= 1'b1;
         q.l.sda_q <= 1'b1;
         start_q <= 1'b0;
      end else begin
         q <= next_q;
         start_q <= next_start;
      end
   end

   // Open drain: the pins are only ever pulled low.
   assign prdata = q.b.prdata;
   assign pready = q.b.pready;
   assign pslverr = q.b.pslverr;
   assign scl_out = 1'b0;
   assign scl_oe = q.l.scl_low;
   assign sda_out = 1'b0;
   assign sda_oe = q.l.sda_low;
   assign wake_req = q.r.wake_req;
   assign start_issue = start_q;

endmodule : two_wire_slave_receiver

// ---- verification/two_wire_slave_assertions.sv ----
/* Port checker for the two-wire slave receiver.
   Bound to the design; shadows control bits from completed APB writes. */
`timescale 1ns/1ns
module two_wire_slave_assertions (
   // Clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // APB
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [31:0] prdata,
   input wire logic pready,
   input wire logic pslverr,
   // Bus and system
   input wire logic scl_in,
   input wire logic sda_in,
   input wire logic scl_oe,
   input wire logic sda_oe,
   input wire logic wake_req,
   input wire logic start_issue
);
   import two_wire_slave_pkg::*;
   logic wr;
   logic en_sh;
   logic sleep_sh;
   logic [3:0] since_clr;
   logic clr_now;
   assign wr = psel && penable && pready && pwrite;
   assign clr_now = wr && paddr == OFS_BUS_CONTROL_REG && pwdata[CTL_EVENT_FLAG];
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         en_sh <= 1'b0;
         sleep_sh <= 1'b0;
         since_clr <= 4'hF;
      end else begin
         if (wr && paddr == OFS_BUS_CONTROL_REG)
            en_sh <= pwdata[CTL_IFACE_ENABLE];
         if (wr && paddr == OFS_SLEEP_CTRL)
            sleep_sh <= pwdata[0];
         if (wr && paddr == OFS_BUS_CONTROL_REG && pwdata[CTL_EVENT_FLAG])
            since_clr <= 4'h0;
         else if (since_clr != 4'hF)
            since_clr <= since_clr + 4'h1;
      end
   end
   default clocking @(posedge pclk); endclocking
   default disable iff (!presetn);
   a_ready_one_wait: assert property (psel && penable && !pready |=> pready)
      else $error("pready not one cycle after access");
   a_ready_pulse: assert property (pready |=> !pready)
      else $error("pready longer than one cycle");
   a_err_read_zero: assert property (pready && pslverr && !pwrite |-> prdata == 32'h0)
      else $error("refused read not zero");
   a_start_one_pulse: assert property (start_issue |=> !start_issue)
      else $error("start pulse too long");
   a_start_bus_free: assert property (start_issue |-> scl_in && sda_in)
      else $error("start while bus busy");
   a_stretch_release: assert property ($fell(scl_oe) |-> clr_now || since_clr < 4'h4)
      else $error("scl released without flag clear");
   a_enable_gate: assert property (!en_sh |-> !scl_oe && !sda_oe)
      else $error("bus driven while disabled");
   a_wake_in_sleep: assert property ($rose(wake_req) |-> sleep_sh)
      else $error("wake outside deep sleep");
   c_wake: cover property ($rose(wake_req));
   c_start: cover property (start_issue);
   c_release: cover property ($fell(scl_oe));
endmodule : two_wire_slave_assertions

bind two_wire_slave_receiver two_wire_slave_assertions chk (
   .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
   .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
   .pready(pready), .pslverr(pslverr), .scl_in(scl_in), .sda_in(sda_in),
   .scl_oe(scl_oe), .sda_oe(sda_oe), .wake_req(wake_req),
   .start_issue(start_issue));

// ---- verification/two_wire_master_model.sv ----
/* Behavioural two-wire master transmitter and receiver, one bit per 17 pclk (170 ns) without stretching.
   Drives open-drain pull enables; the bench forms the wired levels. */
`timescale 1ns/1ns
module two_wire_master_model (
   // Clock
   input wire logic pclk,
   // Wired bus levels
   input wire logic scl,
   input wire logic sda,
   // Pull-low enables
   output logic scl_low,
   output logic sda_low
);
   initial begin
      scl_low = 1'b0;
      sda_low = 1'b0;
   end
   task automatic quarter();
      repeat (4) @(posedge pclk);
   endtask : quarter
   // The slave may stretch SCL, so the wait is bounded rather than trusted.
   task automatic rise_scl();
      int n;
      scl_low <= 1'b0;
      n = 0;
      @(posedge pclk);
      while (!scl && n < 5000) begin
         @(posedge pclk);
         n++;
      end
   endtask : rise_scl
   task automatic clock_bit(input logic b, output logic r);
      sda_low <= !b;
      quarter();
      rise_scl();
      quarter();
      r = sda;
      quarter();
      scl_low <= 1'b1;
      quarter();
   endtask : clock_bit
   task automatic start_cond();
      sda_low <= 1'b1;
      quarter();
      scl_low <= 1'b1;
      quarter();
   endtask : start_cond
   task automatic stop_cond();
      sda_low <= 1'b1;
      quarter();
      rise_scl();
      quarter();
      sda_low <= 1'b0;
      quarter();
   endtask : stop_cond
   task automatic send_byte(input logic [7:0] v, output logic ack);
      logic r;
      for (int i = 7; i >= 0; i--) clock_bit(v[i], r);
      clock_bit(1'b1, r);
      ack = !r;
   endtask : send_byte
   task automatic read_byte(input logic ack, output logic [7:0] v);
      logic r;
      for (int i = 7; i >= 0; i--) begin
         clock_bit(1'b1, r);
         v[i] = r;
      end
      clock_bit(!ack, r);
   endtask : read_byte
endmodule : two_wire_master_model

// ---- verification/tb_two_wire_slave_receiver.sv ----
/* Self-checking bench for the two-wire slave receiver.
   Software acts through APB tasks; the master model drives the bus. */
`timescale 1ns/1ns
module tb_two_wire_slave_receiver;
   import two_wire_slave_pkg::*;
   logic pclk = 1'b0;
   logic presetn = 1'b0;
   logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0, arb_lost_in = 1'b0;
   logic [7:0] paddr = 8'h00;
   logic [31:0] pwdata = 32'h0, prdata, rd;
   logic pready, pslverr, scl_out, scl_oe, sda_out, sda_oe, wake_req, start_issue;
   logic m_scl_low, m_sda_low, scl_w, sda_w, ack, err;
   logic [6:0] own;
   logic [7:0] v, got;
   logic [7:0] st_tab [4] = '{ST_IDLE, ST_GENERAL_CALL, ST_ARB_OWN_WRITE, ST_ARB_GENERAL_CALL};
   int fails = 0;
   int compares = 0;
   int starts = 0;
   assign scl_w = !(m_scl_low || scl_oe);
   assign sda_w = !(m_sda_low || sda_oe);
   always #5 pclk = ~pclk;
   always @(posedge pclk) if (start_issue === 1'b1) starts++;
   two_wire_slave_receiver DUT (.pclk(pclk), .presetn(presetn), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
      .prdata(prdata), .pready(pready), .pslverr(pslverr), .scl_in(scl_w),
      .scl_out(scl_out), .scl_oe(scl_oe), .sda_in(sda_w), .sda_out(sda_out),
      .sda_oe(sda_oe), .arb_lost_in(arb_lost_in), .wake_req(wake_req),
      .start_issue(start_issue));
   two_wire_master_model master (.pclk(pclk), .scl(scl_w), .sda(sda_w),
      .scl_low(m_scl_low), .sda_low(m_sda_low));
   task automatic close_out();
      if (fails == 0 && compares > 0) $display("Run complete: PASS");
      else $display("Run complete: FAIL");
      $finish;
   endtask : close_out
   task automatic check(input string what, input logic [31:0] exp, input logic [31:0] seen);
      compares++;
      if (seen !== exp) begin
         fails++;
         $display("MISMATCH %s expected %h seen %h", what, exp, seen);
      end
   endtask : check
   function automatic logic [7:0] data_status(input logic gc, input logic acked);
      if (gc) return acked ? ST_GC_DATA_ACK : ST_GC_DATA_NACK;
      return acked ? ST_OWN_DATA_ACK : ST_OWN_DATA_NACK;
   endfunction : data_status
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      int n;
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      n = 0;
      do begin
         @(posedge pclk);
         n++;
      end while (pready !== 1'b1 && n < 50);
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      if (n >= 50) fails++;
      @(posedge pclk);
   endtask : apb
   task automatic expect_reg(input string what, input logic [7:0] a, input logic [31:0] exp);
      apb(1'b0, a, 32'h0);
      check(what, exp, rd);
   endtask : expect_reg
   task automatic address(input logic [6:0] a, input logic rw, input logic exp_ack,
      input logic [7:0] exp_st);
      master.start_cond();
      master.send_byte({a, rw}, ack);
      check("address ack", exp_ack, ack);
      expect_reg("status", OFS_BUS_STATUS_REG, exp_st);
      if (exp_ack) check("scl stretched", 32'h1, scl_oe);
      check("pin drive levels", 32'h0, {scl_out, sda_out});
   endtask : address
   task automatic data_byte(input logic exp_ack, input logic [7:0] exp_st);
      v = 8'($urandom);
      master.send_byte(v, ack);
      check("data ack", exp_ack, ack);
      expect_reg("data status", OFS_BUS_STATUS_REG, exp_st);
   endtask : data_byte
   initial begin
      repeat (60000) @(posedge pclk);
      fails++;
      close_out();
   end
   initial begin
      void'($urandom(6280));
      repeat (20) @(posedge pclk);
      presetn <= 1'b1;
      @(posedge pclk);
      expect_reg("status reset", OFS_BUS_STATUS_REG, ST_IDLE);
      expect_reg("addr reset", OFS_OWN_SLAVE_ADDRESS, RST_OWN_SLAVE_ADDRESS);
      expect_reg("ctrl reset", OFS_BUS_CONTROL_REG, RST_BUS_CONTROL_REG);
      apb(1'b1, 8'h14, 32'hFFFF_FFFF);
      check("unmapped write err", 32'h1, err);
      expect_reg("unmapped read", 8'h14, 32'h0);
      own = 7'($urandom_range(2, 127));
      apb(1'b1, OFS_OWN_SLAVE_ADDRESS, {24'h0, own, 1'b1});
      apb(1'b1, OFS_BUS_CONTROL_REG, 32'h40);
      address(own, 1'b0, 1'b0, ST_IDLE);
      master.stop_cond();
      for (int k = 0; k < 3; k++) begin
         own = 7'($urandom_range(2, 127));
         apb(1'b1, OFS_OWN_SLAVE_ADDRESS, {24'h0, own, 1'b1});
         apb(1'b1, OFS_BUS_CONTROL_REG, 32'h44);
         address(own ^ 7'h01, 1'b0, 1'b0, ST_IDLE);
         master.stop_cond();
         address(own, 1'b0, 1'b1, ST_OWN_WRITE);
         apb(1'b1, OFS_BUS_CONTROL_REG, 32'hC4);
         data_byte(1'b1, ST_OWN_DATA_ACK);
         expect_reg("data reg", OFS_BUS_DATA_REG, v);
         apb(1'b1, OFS_BUS_CONTROL_REG, 32'h84);
         data_byte(1'b0, data_status(1'b0, 1'b0));
         apb(1'b1, OFS_BUS_CONTROL_REG, 32'hC4);
         master.stop_cond();
      end
      for (int k = 0; k < 4; k++) begin
         apb(1'b1, OFS_OWN_SLAVE_ADDRESS, {24'h0, own, k != 0});
         arb_lost_in <= k[1];
         @(posedge pclk);
         arb_lost_in <= 1'b0;
         address(k == 2 ? own : GENERAL_CALL_ADDRESS, 1'b0, k != 0, st_tab[k]);
         if (k != 0) begin
            apb(1'b1, OFS_BUS_CONTROL_REG, k == 3 ? 32'h84 : 32'hC4);
            data_byte(k != 3, data_status(k != 2, k != 3));
            apb(1'b1, OFS_BUS_CONTROL_REG, 32'hC4);
         end
         master.stop_cond();
      end
      apb(1'b1, OFS_BUS_CONTROL_REG, 32'h04);
      address(own, 1'b0, 1'b0, ST_IDLE);
      master.stop_cond();
      apb(1'b1, OFS_BUS_CONTROL_REG, 32'h44);
      address(own, 1'b1, 1'b1, ST_OWN_READ);
      v = 8'($urandom);
      apb(1'b1, OFS_BUS_DATA_REG, {24'h0, v});
      apb(1'b1, OFS_BUS_CONTROL_REG, 32'h84);
      master.read_byte(1'b1, got);
      check("sent byte", v, got);
      expect_reg("last byte status", OFS_BUS_STATUS_REG, ST_LAST_BYTE_ACKED);
      starts = 0;
      apb(1'b1, OFS_BUS_CONTROL_REG, 32'hA4);
      master.stop_cond();
      for (int n = 0; n < 200 && starts == 0; n++) @(posedge pclk);
      check("start pulses", 32'h1, starts);
      address(own, 1'b0, 1'b0, ST_IDLE);
      master.stop_cond();
      apb(1'b1, OFS_BUS_CONTROL_REG, 32'h44);
      apb(1'b1, OFS_SLEEP_CTRL, 32'h1);
      address(own, 1'b0, 1'b1, ST_OWN_WRITE);
      check("wake", 32'h1, wake_req);
      repeat (40) @(posedge pclk);
      check("held in wake", 32'h1, scl_oe);
      apb(1'b1, OFS_BUS_CONTROL_REG, 32'hC4);
      data_byte(1'b1, ST_OWN_DATA_ACK);
      apb(1'b1, OFS_SLEEP_CTRL, 32'h2);
      check("wake cleared", 32'h0, wake_req);
      apb(1'b1, OFS_BUS_CONTROL_REG, 32'hC4);
      master.stop_cond();
      close_out();
   end
endmodule : tb_two_wire_slave_receiver
